// >>> hw/eid_id_page.sv
// identification page, lock status and lock logic behind a sampled serial port

// buffer with valid and ready on both sides and a flush
module eid_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             flush_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr_ptr;
        logic [AW:0]                 rd_ptr;
    } eid_fifo_state_t;

    eid_fifo_state_t r;
    eid_fifo_state_t n;
    logic            full;
    logic            empty;

    // pointer step with wrap bit
    function automatic logic [AW:0] ptr_next(input logic [AW:0] p);
        ptr_next = AW'(1) + p;
    endfunction

    // full when indexes match and wrap bits differ
    assign full        = (r.wr_ptr[AW] != r.rd_ptr[AW]) && (r.wr_ptr[AW-1:0] == r.rd_ptr[AW-1:0]);
    assign empty       = (r.wr_ptr == r.rd_ptr);
    assign in_ready_o  = ~full;
    assign out_valid_o = ~empty;
    assign out_data_o  = r.mem[r.rd_ptr[AW-1:0]];

    // next state: push, pop, flush
    always_comb begin
        n = r;
        if (in_valid_i && !full) begin
            n.mem[r.wr_ptr[AW-1:0]] = in_data_i;
            n.wr_ptr                = ptr_next(r.wr_ptr);
        end
        if (out_ready_i && !empty) begin
            n.rd_ptr = ptr_next(r.rd_ptr);
        end
        if (flush_i) begin
            n.wr_ptr = '0;
            n.rd_ptr = '0;
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// device-side serial decoder for the identification page
module eid_id_page #(
    parameter int unsigned WRITE_CYCLES = eid_pkg::WRITE_CYCLES
) (
    input  wire logic CLK_I,
    input  wire logic RSTN_I,
    input  wire logic SPI_CS_N_I,
    input  wire logic SPI_SCK_I,
    input  wire logic SPI_MOSI_I,
    input  wire logic BLOCK_GUARD_HIGH_I,
    input  wire logic BLOCK_GUARD_LOW_I,
    output logic      SPI_MISO_O,
    output logic      SPI_MISO_OE_O,
    output logic      WRITE_CYCLE_ACTIVE_O,
    output logic      WRITE_ENABLE_LATCH_O,
    output logic      ID_PAGE_LOCKED_O
);
    typedef struct packed {
        logic                                               cs_s1;
        logic                                               cs_s2;
        logic                                               cs_d;
        logic                                               sck_s1;
        logic                                               sck_s2;
        logic                                               sck_d;
        logic                                               mosi_s1;
        logic                                               mosi_s2;
        logic                                               write_enable_latch;
        logic                                               busy;
        logic                                               locked;
        logic                                               lock_req;
        logic                                               kind_sel;
        logic                                               pend_lock;
        logic                                               addr_hi_done;
        eid_pkg::eid_phase_t                                phase;
        logic [2:0]                                         bit_cnt;
        logic [7:0]                                         shift;
        logic [7:0]                                         opcode;
        logic [7:0]                                         addr_hi;
        logic [eid_pkg::PAGE_ADDR_W-1:0]                    ptr;
        logic [1:0]                                         data_cnt;
        logic [7:0]                                         out_sh;
        logic [2:0]                                         out_cnt;
        logic                                               miso;
        logic                                               miso_oe;
        logic [31:0]                                        timer;
        logic [eid_pkg::PAGE_BYTES-1:0][7:0]                page;
        logic [eid_pkg::PAGE_BYTES-1:0][7:0]                stage;
        logic [eid_pkg::PAGE_BYTES-1:0]                     mark;
    } eid_state_t;

    eid_state_t r;
    eid_state_t n;
    logic       fifo_in_valid;
    logic [7:0] fifo_in_data;
    logic       fifo_in_ready;
    logic       fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic       fifo_pop;
    logic       cs_rise;
    logic       cs_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       selected;
    logic [7:0] rx_byte;
    logic [7:0] lock_byte;

    // edges are taken from the second synchroniser stage and its delayed copy
    assign cs_rise   = r.cs_s2 & ~r.cs_d;
    assign cs_fall   = ~r.cs_s2 & r.cs_d;
    assign sck_rise  = r.sck_s2 & ~r.sck_d;
    assign sck_fall  = ~r.sck_s2 & r.sck_d;
    assign selected  = ~r.cs_s2;
    assign rx_byte   = {r.shift[6:0], r.mosi_s2};
    assign lock_byte = 8'(r.locked) << eid_pkg::LOCK_FLAG_BIT;

    // read-ahead: page bytes, or the lock byte, fill the buffer until it pushes back
    assign fifo_in_valid = selected && (r.phase == eid_pkg::PH_READ);
    assign fifo_in_data  = r.kind_sel ? lock_byte : r.page[r.ptr];
    assign fifo_pop      = sck_fall && selected && (r.phase == eid_pkg::PH_READ)
                           && (r.out_cnt == 3'h0) && fifo_out_valid;

    eid_fifo #(
        .WIDTH (eid_pkg::FIFO_WIDTH),
        .DEPTH (eid_pkg::FIFO_DEPTH)
    ) u_read_fifo (
        .clk_i       (CLK_I),
        .rstn_i      (RSTN_I),
        .flush_i     (r.cs_s2),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (fifo_in_data),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    // next state of the whole block
    always_comb begin
        n = r;
        n.cs_s1   = SPI_CS_N_I;
        n.cs_s2   = r.cs_s1;
        n.cs_d    = r.cs_s2;
        n.sck_s1  = SPI_SCK_I;
        n.sck_s2  = r.sck_s1;
        n.sck_d   = r.sck_s2;
        n.mosi_s1 = SPI_MOSI_I;
        n.mosi_s2 = r.mosi_s1;

        // a frame starts only on a falling chip select edge
        if (cs_fall) begin
            n.phase        = eid_pkg::PH_OPCODE;
            n.bit_cnt      = 3'h0;
            n.addr_hi_done = 1'b0;
            n.data_cnt     = 2'h0;
            n.out_cnt      = 3'h0;
        end

        // sample serial input on clock rise
        if (sck_rise && selected && (r.phase != eid_pkg::PH_IDLE)) begin
            n.shift   = rx_byte;
            n.bit_cnt = 3'(r.bit_cnt + 3'h1);
            if (r.bit_cnt == 3'h7) begin
                case (r.phase)
                    eid_pkg::PH_OPCODE: begin
                        n.opcode = rx_byte;
                        n.phase  = eid_pkg::PH_IGNORE;
                        if (rx_byte == eid_pkg::OPC_WRITE_ENABLE) begin
                            n.write_enable_latch = 1'b1;
                        end else if (rx_byte == eid_pkg::OPC_WRITE_DISABLE) begin
                            n.write_enable_latch = 1'b0;
                        end else if (rx_byte == eid_pkg::OPC_READ_ID) begin
                            n.phase = r.busy ? eid_pkg::PH_IGNORE : eid_pkg::PH_ADDR;
                        end else if (rx_byte == eid_pkg::OPC_WRITE_ID) begin
                            n.phase = eid_pkg::PH_ADDR;
                        end
                    end
                    eid_pkg::PH_ADDR: begin
                        if (!r.addr_hi_done) begin
                            n.addr_hi      = rx_byte;
                            n.addr_hi_done = 1'b1;
                        end else begin
                            n.kind_sel = r.addr_hi[eid_pkg::KIND_BIT_IN_HIGH];
                            n.ptr      = rx_byte[eid_pkg::PAGE_ADDR_W-1:0];
                            n.lock_req = 1'b0;
                            n.phase    = (r.opcode == eid_pkg::OPC_READ_ID) ? eid_pkg::PH_READ
                                                                           : eid_pkg::PH_WRITE;
                        end
                    end
                    eid_pkg::PH_WRITE: begin
                        if (r.data_cnt != eid_pkg::DATA_CNT_MAX) begin
                            n.data_cnt = 2'(r.data_cnt + 2'h1);
                        end
                        if (r.kind_sel) begin
                            n.lock_req = rx_byte[eid_pkg::LOCK_REQ_BIT];
                        end else if (!r.busy) begin
                            // page bytes wait in the stage until the write cycle ends
                            n.stage[r.ptr] = rx_byte;
                            n.mark[r.ptr]  = 1'b1;
                            n.ptr          = 6'(r.ptr + 6'h1);
                        end
                    end
                    default: begin
                        n.phase = r.phase;
                    end
                endcase
            end
        end

        // read-ahead pointer steps per buffered byte; lock byte does not step
        if (fifo_in_valid && fifo_in_ready && !r.kind_sel) begin
            n.ptr = 6'(r.ptr + 6'h1);
        end

        // shift output on clock fall, reloading from the buffer at byte start
        if (fifo_pop) begin
            n.miso    = fifo_out_data[7];
            n.out_sh  = {fifo_out_data[6:0], 1'b0};
            n.out_cnt = 3'h7;
        end else if (sck_fall && selected && (r.phase == eid_pkg::PH_READ) && (r.out_cnt != 3'h0)) begin
            n.miso    = r.out_sh[7];
            n.out_sh  = {r.out_sh[6:0], 1'b0};
            n.out_cnt = 3'(r.out_cnt - 3'h1);
        end
        n.miso_oe = selected && (n.phase == eid_pkg::PH_READ);

        // deselect ends any frame at any bit; writes commit only on a clean boundary
        if (cs_rise) begin
            n.phase   = eid_pkg::PH_IDLE;
            n.miso    = 1'b0;
            n.miso_oe = 1'b0;
            n.out_cnt = 3'h0;
            if ((r.phase == eid_pkg::PH_WRITE) && (r.bit_cnt == 3'h0) && (r.data_cnt != 2'h0)
                && r.write_enable_latch && !r.busy) begin
                if (r.kind_sel) begin
                    if ((r.data_cnt == eid_pkg::DATA_CNT_ONE) && r.lock_req
                        && !(BLOCK_GUARD_HIGH_I && BLOCK_GUARD_LOW_I)) begin
                        n.busy      = 1'b1;
                        n.pend_lock = 1'b1;
                        n.write_enable_latch       = 1'b0;
                        n.timer     = 32'h0;
                    end
                end else if (!r.locked) begin
                    n.busy      = 1'b1;
                    n.pend_lock = 1'b0;
                    n.write_enable_latch       = 1'b0;
                    n.timer     = 32'h0;
                end else begin
                    n.mark = '0;
                end
            end else if (!r.busy) begin
                n.mark = '0;
            end
        end

        // self-timed write cycle; the flag holds until the count expires
        if (r.busy) begin
            if (r.timer == 32'(WRITE_CYCLES - 1)) begin
                n.busy = 1'b0;
                if (r.pend_lock) begin
                    n.locked = 1'b1;
                end else begin
                    for (int i = 0; i < eid_pkg::PAGE_BYTES; i++) begin
                        if (r.mark[i]) begin
                            n.page[i] = r.stage[i];
                        end
                    end
                end
                n.mark      = '0;
                n.pend_lock = 1'b0;
            end else begin
                n.timer = 32'(r.timer + 32'h1);
            end
        end
    end

    // state register; power-up gives the delivery state
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            r         <= '0;
            r.cs_s1   <= eid_pkg::RST_CS_SYNC;
            r.cs_s2   <= eid_pkg::RST_CS_SYNC;
            r.cs_d    <= eid_pkg::RST_CS_SYNC;
            r.write_enable_latch     <= eid_pkg::RST_WEL;
            r.busy    <= eid_pkg::RST_BUSY;
            r.locked  <= eid_pkg::RST_LOCKED;
            r.phase   <= eid_pkg::PH_IDLE;
            r.page    <= {eid_pkg::PAGE_BYTES{eid_pkg::ERASED_BYTE}};
            r.stage   <= {eid_pkg::PAGE_BYTES{eid_pkg::ERASED_BYTE}};
        end else begin
            r <= n;
        end
    end

    // outputs straight from state
    assign SPI_MISO_O           = r.miso;
    assign SPI_MISO_OE_O        = r.miso_oe;
    assign WRITE_CYCLE_ACTIVE_O = r.busy;
    assign WRITE_ENABLE_LATCH_O = r.write_enable_latch;
    assign ID_PAGE_LOCKED_O     = r.locked;
endmodule

// >>> hw/eid_pkg.sv
// shared constants and types for the identification-page access block
package eid_pkg;

    // instruction codes
    localparam logic [7:0] OPC_WRITE_ENABLE  = 8'h06; // write_enable_command
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_ID       = 8'hA3; // page read, or lock status when page_kind_select_bit set
    localparam logic [7:0] OPC_WRITE_ID      = 8'hA2; // page write, or lock when page_kind_select_bit set

    // page layout
    localparam int         PAGE_BYTES        = 64;
    localparam int         PAGE_ADDR_W       = 6;
    localparam int         KIND_BIT_IN_HIGH  = 2;     // page_kind_select_bit (address bit 10) inside the high address byte
    localparam int         LOCK_REQ_BIT      = 1;     // data bit that must be 1 for a lock
    localparam int         LOCK_FLAG_BIT     = 0;     // lock flag position in the lock status byte
    localparam logic [7:0] ERASED_BYTE       = 8'hFF; // delivery content of every page byte
    localparam logic [1:0] DATA_CNT_ONE      = 2'h1;
    localparam logic [1:0] DATA_CNT_MAX      = 2'h2;

    // reset values
    localparam logic       RST_LOCKED        = 1'b0;
    localparam logic       RST_WEL           = 1'b0;
    localparam logic       RST_BUSY          = 1'b0;
    localparam logic       RST_CS_SYNC       = 1'b0;  // selected level, so a power-up with chip select low starts nothing

    // timing
    localparam int unsigned CLK_PERIOD_NS    = 5;
    localparam int unsigned WRITE_TIME_MS    = 5;     // self_timed_write_time
    localparam int unsigned WRITE_CYCLES     = (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // read path buffer
    localparam int         FIFO_WIDTH        = 8;
    localparam int         FIFO_DEPTH        = 32;

    // serial frame phases
    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,
        PH_OPCODE = 3'h1,
        PH_ADDR   = 3'h2,
        PH_READ   = 3'h3,
        PH_WRITE  = 3'h4,
        PH_IGNORE = 3'h5
    } eid_phase_t;

endpackage

// >>> test/eid_id_page_assertions.sv
// concurrent checks on the identification-page block, bound to its top module
module eid_id_page_checker #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic CLK_I,
    input wire logic RSTN_I,
    input wire logic SPI_CS_N_I,
    input wire logic SPI_SCK_I,
    input wire logic SPI_MOSI_I,
    input wire logic BLOCK_GUARD_HIGH_I,
    input wire logic BLOCK_GUARD_LOW_I,
    input wire logic SPI_MISO_O,
    input wire logic SPI_MISO_OE_O,
    input wire logic WRITE_CYCLE_ACTIVE_O,
    input wire logic WRITE_ENABLE_LATCH_O,
    input wire logic ID_PAGE_LOCKED_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);

    int unsigned busy_len;

    // length so far of the running write cycle, in clocks
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            busy_len <= 0;
        end else begin
            busy_len <= WRITE_CYCLE_ACTIVE_O ? busy_len + 1 : 0;
        end
    end

    // chip select seen high long enough for the synchroniser to follow
    sequence cs_idle;
        SPI_CS_N_I [*6];
    endsequence

    // first clock of a self-timed write cycle
    sequence cycle_start;
        !WRITE_CYCLE_ACTIVE_O ##1 WRITE_CYCLE_ACTIVE_O;
    endsequence

    chk_reset_quiet: assert property (disable iff (1'b0)
        !RSTN_I |-> !(SPI_MISO_OE_O || WRITE_CYCLE_ACTIVE_O || WRITE_ENABLE_LATCH_O || ID_PAGE_LOCKED_O))
        else $error("outputs not cleared during reset");
    chk_read_ignored: assert property (
        WRITE_CYCLE_ACTIVE_O |-> !$rose(SPI_MISO_OE_O))
        else $error("read answered during write cycle");
    chk_lock_sticky: assert property (
        ID_PAGE_LOCKED_O |=> ID_PAGE_LOCKED_O)
        else $error("page lock was undone");
    chk_lock_at_end: assert property (
        $rose(ID_PAGE_LOCKED_O) |-> $fell(WRITE_CYCLE_ACTIVE_O))
        else $error("lock set outside write cycle end");
    chk_cycle_length: assert property (
        $fell(WRITE_CYCLE_ACTIVE_O) |-> busy_len == WRITE_CYCLES)
        else $error("write cycle length wrong");
    chk_cycle_bounded: assert property (
        WRITE_CYCLE_ACTIVE_O |-> busy_len < WRITE_CYCLES)
        else $error("write cycle flag stuck high");
    chk_cycle_holds: assert property (
        cycle_start |-> WRITE_CYCLE_ACTIVE_O [*8])
        else $error("write cycle flag dropped early");
    chk_start_latch: assert property (
        cycle_start |-> $past(WRITE_ENABLE_LATCH_O) && !WRITE_ENABLE_LATCH_O)
        else $error("write cycle without latch or latch kept");
    chk_start_deselect: assert property (
        cycle_start |-> SPI_CS_N_I && $past(SPI_CS_N_I, 2))
        else $error("write cycle started while selected");
    chk_oe_deselect: assert property (
        cs_idle |-> !SPI_MISO_OE_O)
        else $error("output enabled while deselected");
endmodule

bind eid_id_page eid_id_page_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .SPI_CS_N_I(SPI_CS_N_I), .SPI_SCK_I(SPI_SCK_I),
    .SPI_MOSI_I(SPI_MOSI_I), .BLOCK_GUARD_HIGH_I(BLOCK_GUARD_HIGH_I), .BLOCK_GUARD_LOW_I(BLOCK_GUARD_LOW_I),
    .SPI_MISO_O(SPI_MISO_O), .SPI_MISO_OE_O(SPI_MISO_OE_O), .WRITE_CYCLE_ACTIVE_O(WRITE_CYCLE_ACTIVE_O),
    .WRITE_ENABLE_LATCH_O(WRITE_ENABLE_LATCH_O), .ID_PAGE_LOCKED_O(ID_PAGE_LOCKED_O));

// >>> test/eid_host.sv
// host serial controller model, mode 0, 160 ns serial clock
module eid_host (
    input  wire logic clk_i,
    input  wire logic miso_i,
    input  wire logic oe_i,
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 16; // half serial period in 5 ns clocks

    logic oe_seen;

    // idle bus: deselected, clock low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        mosi_o = 1'b1;
        oe_seen = 1'b0;
    end

    // notes whether the device drove its output during the frame
    always @(posedge clk_i) begin
        if (oe_i === 1'b1) oe_seen <= 1'b1;
    end

    // one frame of n bits, msb first; returns bits sampled before each rise
    task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
        rx = '0;
        oe_seen = 1'b0;
        cs_n_o = 1'b0; // frame begins on falling chip select
        repeat (HALF) @(negedge clk_i);
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = tx[i];
            repeat (HALF) @(negedge clk_i);
            rx = {rx[62:0], miso_i};
            sck_o = 1'b1;
            repeat (HALF) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (HALF) @(negedge clk_i);
        cs_n_o = 1'b1; // deselect after the last rise, before any further one
        mosi_o = ~mosi_o; // released line shows the inverse of its last value
        repeat (8) @(negedge clk_i);
    endtask
endmodule

// >>> test/testbench.sv
// self-checking bench for the identification-page block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WCYC = 2000; // shortened write time so a read fits inside it

    logic        clk = 1'b0;
    logic        rstn = 1'b1;     // power_up drops it at time 0 so the reset edge is seen
    logic        guard_hi = 1'b0;
    logic        guard_lo = 1'b0;
    wire logic   cs_n, sck, mosi, miso, oe, busy, write_enable_latch, locked;
    int          n_errors = 0;
    int          checked = 0;
    logic [63:0] rx;
    logic [63:0] lk_tx [4];
    int          lk_n [4];

    // 200 MHz system clock
    always #2.5 clk = ~clk;

    eid_host host (.clk_i(clk), .miso_i(miso), .oe_i(oe), .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi));

    eid_id_page #(.WRITE_CYCLES(WCYC)) dut (
        .CLK_I(clk), .RSTN_I(rstn), .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck), .SPI_MOSI_I(mosi),
        .BLOCK_GUARD_HIGH_I(guard_hi), .BLOCK_GUARD_LOW_I(guard_lo), .SPI_MISO_O(miso),
        .SPI_MISO_OE_O(oe), .WRITE_CYCLE_ACTIVE_O(busy), .WRITE_ENABLE_LATCH_O(write_enable_latch),
        .ID_PAGE_LOCKED_O(locked));

    // compares one value and reports a mismatch
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // prints the verdict and ends the run
    task automatic final_report();
        if (n_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // waits, bounded, for the write cycle to finish
    task automatic wait_done();
        int i;
        i = 0;
        while (busy === 1'b1 && i < 3000) begin
            @(negedge clk);
            i++;
        end
        check("write cycle end", 64'h0, busy);
        if (busy !== 1'b0) final_report();
    endtask

    // pulses reset and checks the power-up state
    task automatic power_up();
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (4) @(negedge clk);
        check("flags after reset", 4'h0, {busy, write_enable_latch, locked, oe});
    endtask

    // main sequence
    initial begin
        lk_tx = '{64'hA2040002, 64'hA2040002, 64'h144080004, 64'hA20400FD};
        lk_n = '{32, 32, 33, 32};
        power_up();
        host.xfer(56, {8'hA3, 8'h00, 8'h00, 32'h0}, rx);
        check("delivered page", 32'hFFFFFFFF, rx[31:0]);
        host.xfer(40, {8'hA3, 8'h04, 8'h00, 16'h0}, rx);
        check("status unlocked", 17'h10000, {host.oe_seen, rx[15:0]});
        host.xfer(8, 8'h06, rx);
        check("latch set", 64'h1, write_enable_latch);
        host.xfer(8, 8'h04, rx);
        check("latch cleared", 64'h0, write_enable_latch);
        host.xfer(8, 8'h06, rx);
        host.xfer(24, {8'hA2, 8'h00, 8'h3E}, rx);
        check("write without data", 2'h1, {busy, write_enable_latch});
        host.xfer(48, {8'hA2, 8'hF8, 8'h3E, 24'h112233}, rx);
        check("write cycle started", 2'h2, {busy, write_enable_latch});
        host.xfer(32, {8'hA3, 8'h00, 8'h3E, 8'h0}, rx);
        check("read while busy", 64'h0, host.oe_seen);
        wait_done();
        host.xfer(48, {8'hA3, 8'hF8, 8'h3E, 24'h0}, rx);
        check("page roll-over", 24'h112233, rx[23:0]);
        host.xfer(37, {8'hA3, 8'h00, 8'h3E, 13'h0}, rx);
        host.xfer(32, {8'hA3, 8'h00, 8'h3F, 8'h0}, rx);
        check("read after abort", 8'h22, rx[7:0]);
        // refused locks: no latch, both guards set, off boundary, request bit clear
        for (int k = 0; k < 4; k++) begin
            guard_hi = (k == 1);
            guard_lo = (k == 1);
            if (k != 0) host.xfer(8, 8'h06, rx);
            host.xfer(lk_n[k], lk_tx[k], rx);
            repeat (8) @(negedge clk);
            check("refused lock", 2'h0, {busy, locked});
        end
        guard_hi = 1'b1;
        guard_lo = 1'b0;
        host.xfer(8, 8'h06, rx);
        host.xfer(32, {8'hA2, 8'hFF, 8'hFF, 8'hFE}, rx);
        check("lock cycle", 64'h1, busy);
        wait_done();
        check("locked", 64'h1, locked);
        host.xfer(40, {8'hA3, 8'h04, 8'h00, 16'h0}, rx);
        check("status repeated", 16'h0101, rx[15:0]);
        host.xfer(8, 8'h06, rx);
        host.xfer(32, {8'hA2, 8'h00, 8'h3E, 8'h77}, rx);
        wait_done();
        host.xfer(32, {8'hA3, 8'h00, 8'h3E, 8'h0}, rx);
        check("locked page kept", 8'h11, rx[7:0]);
        check("lock kept", 64'h1, locked);
        power_up();
        final_report();
    end
endmodule
